/* hw/ibi_bus_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Open-drain bus: a line is low if any end enables a low output
// ----------------------------------------------------------------
interface ibi_bus_if;
   logic [15:0] dev_out;   // Device end output values
   logic [15:0] dev_oe;    // Device end drives line
   logic [15:0] ctl_out;   // Controller end output values
   logic [15:0] ctl_oe;    // Controller end drives line
   logic [15:0] lvl;       // Resolved line levels, pulled up
   // Wired-AND with pull-ups
   assign lvl = (dev_out | ~dev_oe) & (ctl_out | ~ctl_oe);
   modport dev (output dev_out, output dev_oe, input lvl);
   modport ctl (output ctl_out, output ctl_oe, input lvl);
endinterface : ibi_bus_if
`default_nettype wire

/* hw/ibi_ctl_end.sv */
`timescale 1ns/1ps
`default_nettype none
`include "ibi_defines.svh"
module ibi_ctl_end #(
   parameter int unsigned IFC_CYC = `IBI_IFC_CYC   // Clear pulse length
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Bus side
   ibi_bus_if.ctl          bus,
   // Control
   input  wire logic       ifc_req_i,
   input  wire logic       ren_i,
   input  wire logic       pp_req_i,
   input  wire logic       listen_i,
   // Bytes to send
   input  wire logic [7:0] cmd_data_i,
   input  wire logic       cmd_atn_i,
   input  wire logic       cmd_eoi_i,
   input  wire logic       cmd_valid_i,
   output logic            cmd_ready_o,
   // Received bytes
   output logic [7:0]      rx_data_o,
   output logic            rx_eoi_o,
   output logic            rx_valid_o,
   input  wire logic       rx_ready_i,
   // Status
   output logic            srq_o,
   output logic [7:0]      pp_data_o,
   output logic            pp_valid_o,
   output logic            ifc_busy_o
);
   import ibi_pkg::*;

   // ----------------------------------------------------------------
   // Line synchronisers
   // ----------------------------------------------------------------
   logic [15:0] s1_r;          // First stage, read by second only
   logic [15:0] s2_r;          // Second stage
   logic [15:0] s3_r;          // Third stage
   logic [15:0] f_r;           // Agreed level

   // Three-stage shift
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_r <= `IBI_LINES_IDLE;
         s2_r <= `IBI_LINES_IDLE;
         s3_r <= `IBI_LINES_IDLE;
      end else begin
         s1_r <= bus.lvl;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accept a change once stages two and three agree
   genvar gi;
   for (gi = 0; gi < 16; gi++) begin : g_flt
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            f_r[gi] <= 1'b1;
         end else if (s2_r[gi] == s3_r[gi]) begin
            f_r[gi] <= s3_r[gi];
         end
      end
   end

   // ----------------------------------------------------------------
   // Clear pulse, attention and parallel poll
   // ----------------------------------------------------------------
   logic [15:0] ifc_cnt_r;      // Clear cycles left
   logic        atn_r;          // Attention held for commands
   logic        pp_r;           // Parallel poll running
   logic [15:0] pp_cnt_r;       // Poll settle counter
   ibi_src_t    src_r;          // Source state
   ibi_acc_t    acc_r;          // Acceptor state
   logic        take;           // Byte taken from the user

   assign ifc_busy_o  = ifc_cnt_r != 16'h0000;
   assign cmd_ready_o = ~ifc_busy_o & ~pp_r & ~pp_req_i & (src_r == SRC_IDLE);
   assign take        = cmd_ready_o & cmd_valid_i;

   // Clear pulse, restartable
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         ifc_cnt_r <= 16'h0000;
      end else if (ifc_req_i) begin
         ifc_cnt_r <= 16'(IFC_CYC);
      end else if (ifc_busy_o) begin
         ifc_cnt_r <= ifc_cnt_r - 16'h0001;
      end
   end

   // Attention follows the kind of the byte taken
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         atn_r <= 1'b0;
      end else if (ifc_busy_o) begin
         atn_r <= 1'b0;
      end else if (take) begin
         atn_r <= cmd_atn_i;
      end
   end

   // Parallel poll: hold attention and end, then sample
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         pp_r       <= 1'b0;
         pp_cnt_r   <= 16'h0000;
         pp_data_o  <= 8'h00;
         pp_valid_o <= 1'b0;
      end else begin
         pp_valid_o <= 1'b0;
         if (ifc_busy_o) begin
            pp_r <= 1'b0;
         end else if (!pp_r && pp_req_i && src_r == SRC_IDLE) begin
            pp_r     <= 1'b1;
            pp_cnt_r <= 16'(`IBI_SETTLE_CYC);
         end else if (pp_r && pp_cnt_r != 16'h0000) begin
            pp_cnt_r <= pp_cnt_r - 16'h0001;
         end else if (pp_r) begin
            pp_r       <= 1'b0;
            pp_data_o  <= ~f_r[`IBI_P_DIO +: 8];
            pp_valid_o <= 1'b1;
         end
      end
   end

   // ----------------------------------------------------------------
   // Source handshake
   // ----------------------------------------------------------------
   logic [7:0]  tx_byte_r;      // Byte on the lines
   logic        tx_end_r;       // Drive end with this byte
   logic [15:0] cnt_r;          // Settle counter

   // Load, settle, valid, release
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         src_r     <= SRC_IDLE;
         tx_byte_r <= 8'h00;
         tx_end_r  <= 1'b0;
         cnt_r     <= 16'h0000;
      end else if (ifc_busy_o) begin
         src_r <= SRC_IDLE;
      end else begin
         case (src_r)
            SRC_IDLE: begin
               if (take) begin
                  tx_byte_r <= cmd_data_i;
                  tx_end_r  <= ~cmd_atn_i & cmd_eoi_i;
                  cnt_r     <= 16'(`IBI_SETTLE_CYC);
                  src_r     <= SRC_SETTLE;
               end
            end
            SRC_SETTLE: begin
               if (cnt_r != 16'h0000) begin
                  cnt_r <= cnt_r - 16'h0001;
               end else if (f_r[`IBI_P_NRFD] && !f_r[`IBI_P_NDAC]) begin
                  src_r <= SRC_VALID;
               end
            end
            SRC_VALID: if (f_r[`IBI_P_NDAC]) src_r <= SRC_REL;
            SRC_REL:   if (!f_r[`IBI_P_NDAC]) src_r <= SRC_IDLE;
            default:   src_r <= SRC_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Acceptor handshake for device data
   // ----------------------------------------------------------------
   logic acc_on;                // Listening to device data
   logic dav_l;                 // Data valid asserted
   assign acc_on = listen_i & ~atn_r & ~pp_r & ~ifc_busy_o & (src_r == SRC_IDLE);
   assign dav_l  = ~f_r[`IBI_P_DAV];

   // Ready, latch, accepted, wait for valid to drop
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_r <= ACC_BUSY;
      end else if (!acc_on) begin
         acc_r <= ACC_BUSY;
      end else begin
         case (acc_r)
            ACC_BUSY:  if (!rx_valid_o && !dav_l) acc_r <= ACC_RDY;
            ACC_RDY:   if (dav_l) acc_r <= ACC_LATCH;
            ACC_LATCH: acc_r <= ACC_DONE;
            ACC_DONE:  if (!dav_l) acc_r <= ACC_BUSY;
            default:   acc_r <= ACC_BUSY;
         endcase
      end
   end

   // Latch the byte; a new byte wins over the clear
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_valid_o <= 1'b0;
         rx_data_o  <= 8'h00;
         rx_eoi_o   <= 1'b0;
      end else if (acc_on && acc_r == ACC_RDY && dav_l) begin
         rx_valid_o <= 1'b1;
         rx_data_o  <= ~f_r[`IBI_P_DIO +: 8];
         rx_eoi_o   <= ~f_r[`IBI_P_EOI];
      end else if (rx_ready_i) begin
         rx_valid_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Line drive
   // ----------------------------------------------------------------
   logic [15:0] oe_c;           // Enables, low output
   logic        src_drv;        // Byte is on the lines
   assign src_drv = (src_r == SRC_SETTLE) | (src_r == SRC_VALID);

   // Open-drain enables; a driven low is a one
   always_comb begin
      oe_c = 16'h0000;
      if (src_drv) begin
         oe_c[`IBI_P_DIO +: 8] = tx_byte_r;
      end
      oe_c[`IBI_P_ATN]  = atn_r | pp_r;
      oe_c[`IBI_P_DAV]  = src_r == SRC_VALID;
      oe_c[`IBI_P_EOI]  = (src_drv & tx_end_r) | pp_r;
      oe_c[`IBI_P_NRFD] = acc_on & (acc_r != ACC_RDY);
      oe_c[`IBI_P_NDAC] = acc_on & (acc_r != ACC_DONE);
      oe_c[`IBI_P_IFC]  = ifc_busy_o;
      oe_c[`IBI_P_REN]  = ren_i;
   end

   assign bus.ctl_out = 16'h0000;
   assign bus.ctl_oe  = oe_c;

   // Service request seen on the bus
   assign srq_o = ~f_r[`IBI_P_SRQ];

endmodule : ibi_ctl_end
`default_nettype wire

/* hw/ibi_defines.svh */
`ifndef IBI_DEFINES_SVH
`define IBI_DEFINES_SVH
// ----------------------------------------------------------------
// Pin positions within the 16-bit line vector
// ----------------------------------------------------------------
`define IBI_P_DIO     0
`define IBI_P_ATN     8
`define IBI_P_DAV     9
`define IBI_P_NRFD    10
`define IBI_P_NDAC    11
`define IBI_P_EOI     12
`define IBI_P_IFC     13
`define IBI_P_REN     14
`define IBI_P_SRQ     15
`define IBI_LINES_IDLE 16'hffff
// ----------------------------------------------------------------
// Interface command bytes (parity bit ignored)
// ----------------------------------------------------------------
`define IBI_CMD_GET   7'h08
`define IBI_CMD_SPE   7'h18
`define IBI_CMD_SPD   7'h19
`define IBI_GRP_LISTEN 2'h1
`define IBI_GRP_TALK   2'h2
`define IBI_ADDR_NONE  5'h1f
// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define IBI_CLK_MHZ    125
`define IBI_SETTLE_NS  500
`define IBI_SETTLE_CYC ((`IBI_SETTLE_NS * `IBI_CLK_MHZ + 999) / 1000)
`define IBI_IFC_US     100
`define IBI_IFC_CYC    (`IBI_IFC_US * `IBI_CLK_MHZ)
`endif

/* hw/ibi_dev_end.sv */
// Operation
// - Only the controller in charge drives attention.
// - Attention low: commands; high: device data.
// - Data lines inverted: low level means one.
// - Data valid only with byte and ready.
// - Release ready only when able to accept.
// - Release accepted only after latching byte.
// - End line marks last byte or poll.
// - Interface clear aborts, unaddresses, ends serial poll.
// - Remote while enable low, local otherwise.
// - Service request low while attention needed.
`timescale 1ns/1ps
`default_nettype none
`include "ibi_defines.svh"
module ibi_dev_end #(
   parameter logic [4:0] ADDR = 5'h01     // Bus address of this instrument
) (
   // Clock and reset
   input  wire logic       clk_i,
   input  wire logic       nrst_i,
   // Bus side
   ibi_bus_if.dev          bus,
   // Received data bytes
   output logic [7:0]      rx_data_o,
   output logic            rx_eoi_o,
   output logic            rx_valid_o,
   input  wire logic       rx_ready_i,
   // Bytes to talk
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_eoi_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   // Service request and poll status
   input  wire logic       srq_i,
   input  wire logic [5:0] stb_i,
   input  wire logic       pp_en_i,
   input  wire logic [2:0] pp_line_i,
   // Status
   output logic            trig_o,
   output logic            remote_o,
   output logic            listen_o,
   output logic            talk_o,
   output logic            spoll_o,
   output logic            clear_o
);
   import ibi_pkg::*;

   // ----------------------------------------------------------------
   // Line synchronisers
   // ----------------------------------------------------------------
   logic [15:0] s1_r;          // First stage, read by second only
   logic [15:0] s2_r;          // Second stage
   logic [15:0] s3_r;          // Third stage
   logic [15:0] f_r;           // Agreed level

   // Three-stage shift
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         s1_r <= `IBI_LINES_IDLE;
         s2_r <= `IBI_LINES_IDLE;
         s3_r <= `IBI_LINES_IDLE;
      end else begin
         s1_r <= bus.lvl;
         s2_r <= s1_r;
         s3_r <= s2_r;
      end
   end

   // Accept a change once stages two and three agree
   genvar gi;
   for (gi = 0; gi < 16; gi++) begin : g_flt
      always_ff @(posedge clk_i or negedge nrst_i) begin
         if (!nrst_i) begin
            f_r[gi] <= 1'b1;
         end else if (s2_r[gi] == s3_r[gi]) begin
            f_r[gi] <= s3_r[gi];
         end
      end
   end

   // Asserted-sense views of the lines
   logic       atn_l;           // Command mode
   logic       dav_l;           // Data valid asserted
   logic       nrfd_hi;         // All acceptors ready
   logic       ndac_hi;         // All acceptors latched
   logic       eoi_l;           // End or identify asserted
   logic       ifc_l;           // Interface clear asserted
   logic [7:0] byte_in;         // Decoded data byte
   assign atn_l   = ~f_r[`IBI_P_ATN];
   assign dav_l   = ~f_r[`IBI_P_DAV];
   assign nrfd_hi = f_r[`IBI_P_NRFD];
   assign ndac_hi = f_r[`IBI_P_NDAC];
   assign eoi_l   = ~f_r[`IBI_P_EOI];
   assign ifc_l   = ~f_r[`IBI_P_IFC];
   assign byte_in = ~f_r[`IBI_P_DIO +: 8];

   // ----------------------------------------------------------------
   // Addressing state
   // ----------------------------------------------------------------
   ibi_acc_t   acc_r;           // Acceptor state
   ibi_src_t   src_r;           // Source state
   logic [7:0] cap_r;           // Byte captured from the lines
   logic       cap_eoi_r;       // End flag captured with it
   logic       lad_r;           // Addressed to listen
   logic       tad_r;           // Addressed to talk
   logic       spe_r;           // Serial poll enabled
   logic       acc_on;          // Acceptor takes part
   logic       talk_on;         // Source may run
   logic       latch_cmd;       // Command byte latched this cycle
   logic [6:0] cmd;             // Command without parity

   assign acc_on    = atn_l | lad_r;
   assign talk_on   = tad_r & ~atn_l & ~ifc_l;
   assign cmd       = cap_r[6:0];
   assign latch_cmd = (acc_r == ACC_LATCH) & atn_l;

   // Listen and talk addressing, own or other address
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         lad_r <= 1'b0;
         tad_r <= 1'b0;
      end else if (ifc_l) begin
         lad_r <= 1'b0;
         tad_r <= 1'b0;
      end else if (latch_cmd) begin
         if (cmd[6:5] == `IBI_GRP_LISTEN) begin
            if (cmd[4:0] == ADDR) begin
               lad_r <= 1'b1;
            end else if (cmd[4:0] == `IBI_ADDR_NONE) begin
               lad_r <= 1'b0;
            end
         end else if (cmd[6:5] == `IBI_GRP_TALK) begin
            tad_r <= (cmd[4:0] == ADDR);
         end
      end
   end

   // Serial poll enable and trigger pulse
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         spe_r  <= 1'b0;
         trig_o <= 1'b0;
      end else begin
         trig_o <= latch_cmd & lad_r & (cmd == `IBI_CMD_GET) & ~ifc_l;
         if (ifc_l) begin
            spe_r <= 1'b0;
         end else if (latch_cmd && cmd == `IBI_CMD_SPE) begin
            spe_r <= 1'b1;
         end else if (latch_cmd && cmd == `IBI_CMD_SPD) begin
            spe_r <= 1'b0;
         end
      end
   end

   // ----------------------------------------------------------------
   // Acceptor handshake
   // ----------------------------------------------------------------
   // Byte loop: ready, latch, accepted, wait for valid to drop
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         acc_r <= ACC_BUSY;
      end else if (ifc_l || !acc_on) begin
         acc_r <= ACC_BUSY;
      end else begin
         case (acc_r)
            ACC_BUSY:  if ((atn_l || !rx_valid_o) && !dav_l) acc_r <= ACC_RDY;
            ACC_RDY:   if (dav_l) acc_r <= ACC_LATCH;
            ACC_LATCH: acc_r <= ACC_DONE;
            ACC_DONE:  if (!dav_l) acc_r <= ACC_BUSY;
            default:   acc_r <= ACC_BUSY;
         endcase
      end
   end

   // Capture the byte when valid is first seen
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         cap_r     <= 8'h00;
         cap_eoi_r <= 1'b0;
      end else if (acc_r == ACC_RDY && dav_l) begin
         cap_r     <= byte_in;
         cap_eoi_r <= eoi_l;
      end
   end

   // Data byte to the user; a new byte wins over the clear
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         rx_valid_o <= 1'b0;
         rx_data_o  <= 8'h00;
         rx_eoi_o   <= 1'b0;
      end else if (acc_r == ACC_LATCH && !atn_l && lad_r && !ifc_l) begin
         rx_valid_o <= 1'b1;
         rx_data_o  <= cap_r;
         rx_eoi_o   <= cap_eoi_r;
      end else if (rx_ready_i) begin
         rx_valid_o <= 1'b0;
      end
   end

   // ----------------------------------------------------------------
   // Source handshake
   // ----------------------------------------------------------------
   logic [7:0]  tx_byte_r;      // Byte on the lines
   logic        tx_end_r;       // Drive end with this byte
   logic [15:0] cnt_r;          // Settle counter

   assign tx_ready_o = talk_on & ~spe_r & (src_r == SRC_IDLE);

   // Load, settle, valid, release
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         src_r     <= SRC_IDLE;
         tx_byte_r <= 8'h00;
         tx_end_r  <= 1'b0;
         cnt_r     <= 16'h0000;
      end else if (!talk_on) begin
         src_r <= SRC_IDLE;
      end else begin
         case (src_r)
            SRC_IDLE: begin
               if (spe_r || tx_valid_i) begin
                  tx_byte_r <= spe_r ? {1'b0, srq_i, stb_i} : tx_data_i;
                  tx_end_r  <= ~spe_r & tx_eoi_i;
                  cnt_r     <= 16'(`IBI_SETTLE_CYC);
                  src_r     <= SRC_SETTLE;
               end
            end
            SRC_SETTLE: begin
               if (cnt_r != 16'h0000) begin
                  cnt_r <= cnt_r - 16'h0001;
               end else if (nrfd_hi && !ndac_hi) begin
                  src_r <= SRC_VALID;
               end
            end
            SRC_VALID: if (ndac_hi) src_r <= SRC_REL;
            SRC_REL:   if (!ndac_hi) src_r <= SRC_IDLE;
            default:   src_r <= SRC_IDLE;
         endcase
      end
   end

   // ----------------------------------------------------------------
   // Line drive
   // ----------------------------------------------------------------
   logic [15:0] oe_c;           // Enables, low output
   logic        src_drv;        // Byte is on the lines
   logic        pp_drv;         // Parallel poll answer

   assign src_drv = (src_r == SRC_SETTLE) | (src_r == SRC_VALID);
   assign pp_drv  = atn_l & eoi_l & pp_en_i & srq_i;

   // Open-drain enables; a driven low is a one
   always_comb begin
      oe_c = 16'h0000;
      if (src_drv) begin
         oe_c[`IBI_P_DIO +: 8] = tx_byte_r;
      end else if (pp_drv) begin
         oe_c[`IBI_P_DIO + 32'(pp_line_i)] = 1'b1;
      end
      oe_c[`IBI_P_DAV]  = src_r == SRC_VALID;
      oe_c[`IBI_P_EOI]  = src_drv & tx_end_r;
      oe_c[`IBI_P_NRFD] = acc_on & ~ifc_l & (acc_r != ACC_RDY);
      oe_c[`IBI_P_NDAC] = acc_on & ~ifc_l & (acc_r != ACC_DONE);
      oe_c[`IBI_P_SRQ]  = srq_i;
   end

   assign bus.dev_out = 16'h0000;
   assign bus.dev_oe  = oe_c;

   // Status outputs
   always_ff @(posedge clk_i or negedge nrst_i) begin
      if (!nrst_i) begin
         remote_o <= 1'b0;
         clear_o  <= 1'b0;
      end else begin
         remote_o <= ~f_r[`IBI_P_REN];
         clear_o  <= ifc_l;
      end
   end

   assign listen_o = lad_r;
   assign talk_o   = tad_r;
   assign spoll_o  = spe_r;

endmodule : ibi_dev_end
`default_nettype wire

/* hw/ibi_pkg.sv */
package ibi_pkg;
   // Acceptor handshake states, Gray along the loop
   typedef enum logic [1:0] {
      ACC_BUSY  = 2'h0,
      ACC_RDY   = 2'h1,
      ACC_LATCH = 2'h3,
      ACC_DONE  = 2'h2
   } ibi_acc_t;
   // Source handshake states, Gray along the loop
   typedef enum logic [1:0] {
      SRC_IDLE   = 2'h0,
      SRC_SETTLE = 2'h1,
      SRC_VALID  = 2'h3,
      SRC_REL    = 2'h2
   } ibi_src_t;
endpackage

/* test/ibi_bus_checker.sv */
`timescale 1ns/1ps
`default_nettype none
module ibi_bus_checker (
   // Clock and reset
   input wire logic        clk_i,
   input wire logic        nrst_i,
   // Bus lines
   input wire logic [15:0] dev_out,
   input wire logic [15:0] dev_oe,
   input wire logic [15:0] ctl_out,
   input wire logic [15:0] ctl_oe,
   input wire logic [15:0] lvl
);
   // -------------------------------------------------------------
   // Wire rules
   // -------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!nrst_i);
   // Instrument never drives attention
   property p_atn_own; dev_oe[8] == 1'b0; endproperty
   a_atn_own: assert property (p_atn_own) else $error("device drove attention");
   // Open drain, pulled low means one
   property p_drain; dev_out == 16'h0000 && ctl_out == 16'h0000; endproperty
   a_drain: assert property (p_drain) else $error("line driven high");
   // Valid falls only with ready high
   property p_dav_rdy; $fell(lvl[9]) |-> lvl[10]; endproperty
   a_dav_rdy: assert property (p_dav_rdy) else $error("valid without ready");
   // Byte holds while valid low
   property p_dio_hold; !lvl[9] && !$past(lvl[9]) && lvl[13] |-> $stable(lvl[7:0]); endproperty
   a_dio_hold: assert property (p_dio_hold) else $error("data moved under valid");
   // Accepted rises only while valid low
   property p_ndac; $rose(lvl[11]) && lvl[13] |-> !lvl[9]; endproperty
   a_ndac: assert property (p_ndac) else $error("accepted without byte");
   // Valid released only after accepted
   property p_dav_rel; $rose(lvl[9]) && lvl[13] |-> lvl[11]; endproperty
   a_dav_rel: assert property (p_dav_rel) else $error("valid dropped early");
   // Ready returns only after valid released
   property p_nrfd; $rose(lvl[10]) && lvl[13] |-> lvl[9]; endproperty
   a_nrfd: assert property (p_nrfd) else $error("ready during valid");
   // Clear releases handshake and attention
   property p_ifc; $fell(lvl[13]) |-> ##[1:12] (dev_oe[11:9] == 3'h0 && ctl_oe[8] == 1'b0); endproperty
   a_ifc: assert property (p_ifc) else $error("clear did not abort");
   // Main scenarios
   c_xfer: cover property ($fell(lvl[9]));
   c_ifc: cover property ($fell(lvl[13]));
   c_eoi: cover property (!lvl[12] && lvl[8] && !lvl[9]);
   c_poll: cover property (!lvl[12] && !lvl[8]);
endmodule // ibi_bus_checker
`default_nettype wire

/* test/tb_ieee488_bus_interface.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_ieee488_bus_interface;
   logic clk_i, nrst_i, ren, srq, ppr, ppe, ifc, cv, ca, ce, rdy, trg, clr;
   logic [7:0] cd, rxd, ppd;
   logic [2:0] pl;
   logic rxe, rxv, trig, clear, rem, lis, crdy, srqo, ppv, busy, spl;
   int bad_count, n_tests, cyc, k;
   ibi_bus_if bus ();
   ibi_dev_end i_ibi_dev_end (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus), .rx_data_o(rxd), .rx_eoi_o(rxe),
      .rx_valid_o(rxv), .rx_ready_i(rdy), .tx_data_i(cd), .tx_eoi_i(ce), .tx_valid_i(1'b0), .tx_ready_o(),
      .srq_i(srq), .stb_i(6'h2a), .pp_en_i(ppe), .pp_line_i(pl), .trig_o(trig), .remote_o(rem),
      .listen_o(lis), .talk_o(), .spoll_o(spl), .clear_o(clear));
   ibi_ctl_end #(.IFC_CYC(20)) i_ibi_ctl_end (.clk_i(clk_i), .nrst_i(nrst_i), .bus(bus), .ifc_req_i(ifc),
      .ren_i(ren), .pp_req_i(ppr), .listen_i(1'b0), .cmd_data_i(cd), .cmd_atn_i(ca), .cmd_eoi_i(ce),
      .cmd_valid_i(cv), .cmd_ready_o(crdy), .rx_data_o(), .rx_eoi_o(), .rx_valid_o(), .rx_ready_i(1'b1),
      .srq_o(srqo), .pp_data_o(ppd), .pp_valid_o(ppv), .ifc_busy_o(busy));
   ibi_bus_checker i_ibi_bus_checker (.clk_i(clk_i), .nrst_i(nrst_i), .dev_out(bus.dev_out),
      .dev_oe(bus.dev_oe), .ctl_out(bus.ctl_out), .ctl_oe(bus.ctl_oe), .lvl(bus.lvl));
   // -------------------------------------------------------------
   // Clock, sticky pulse catchers and timeout
   // -------------------------------------------------------------
   initial begin
      clk_i = 1'b0;
      forever #4 clk_i = ~clk_i;
   end
   always @(posedge clk_i) begin
      trg <= trg | trig;
      clr <= clr | clear;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         bad_count++;
         give_verdict();
      end
   end
   // Compare and count
   task chk(input logic [7:0] s, input logic [7:0] e);
      n_tests++;
      if (s !== e) begin
         bad_count++;
         $display("ERROR %0t seen %h expected %h", $time, s, e);
      end
   endtask
   task tick(input int n);
      repeat (n) @(posedge clk_i);
      #1;
   endtask
   // Controller sends one byte and the wire is checked under valid
   task snd(input logic [7:0] d, input logic a, input logic e);
      {cd, ca, ce, cv} = {d, a, e, 1'b1};
      for (k = 0; k < 300 && crdy !== 1'b1; k++) tick(1);
      @(posedge clk_i);
      #1 cv = 1'b0;
      for (k = 0; k < 300 && bus.lvl[9] !== 1'b0; k++) tick(1);
      chk(bus.lvl[9], 1'b0);
      chk(~bus.lvl[7:0], d);
      chk(bus.lvl[8], !a);
      chk(bus.lvl[12], !e);
      for (k = 0; k < 300 && crdy !== 1'b1; k++) tick(1);
      tick(4);
   endtask
   // Device hands up the byte it latched
   task rcv(input logic [7:0] d, input logic e);
      for (k = 0; k < 300 && rxv !== 1'b1; k++) tick(1);
      chk(rxv, 1'b1);
      chk(rxd, d);
      chk(rxe, e);
      rdy = 1'b1;
      tick(1);
      rdy = 1'b0;
   endtask
   task give_verdict();
      if (bad_count == 0 && n_tests > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // -------------------------------------------------------------
   // Main sequence
   // -------------------------------------------------------------
   initial begin
      {nrst_i, ren, srq, ppr, ppe, ifc, cv, ca, ce, rdy, trg, clr, cd, pl} = '0;
      {bad_count, n_tests, cyc} = '0;
      tick(5);
      nrst_i = 1'b1;
      tick(10);
      chk(rem, 1'b0);
      ren = 1'b1;
      srq = 1'b1;
      tick(10);
      chk(rem, 1'b1);
      chk(bus.lvl[15], 1'b0);
      chk(srqo, 1'b1);
      snd(8'h21, 1'b1, 1'b0);
      chk(lis, 1'b1);
      snd(8'h08, 1'b1, 1'b0);
      chk(trg, 1'b1);
      snd(8'h18, 1'b1, 1'b0);
      chk(spl, 1'b1);
      {ppe, pl, ppr} = {1'b1, 3'h5, 1'b1};
      for (k = 0; k < 300 && ppv !== 1'b1; k++) tick(1);
      chk(ppv, 1'b1);
      chk(ppd, 8'h20);
      ppr = 1'b0;
      tick(10);
      snd(8'ha5, 1'b0, 1'b0);
      rcv(8'ha5, 1'b0);
      snd(8'h3c, 1'b0, 1'b1);
      rcv(8'h3c, 1'b1);
      ifc = 1'b1;
      tick(1);
      ifc = 1'b0;
      for (k = 0; k < 300 && busy !== 1'b0; k++) tick(1);
      tick(10);
      chk(clr, 1'b1);
      chk(lis, 1'b0);
      chk(spl, 1'b0);
      ren = 1'b0;
      srq = 1'b0;
      tick(10);
      chk(rem, 1'b0);
      chk(bus.lvl[15], 1'b1);
      give_verdict();
   end
endmodule // tb_ieee488_bus_interface
`default_nettype wire
